// ### hw/dtr_defs.svh
// constants for the dual timer register bank
`ifndef DTR_DEFS_SVH
`define DTR_DEFS_SVH
// register indices; each register is one word, byte address is index * 4
`define DTR_IDX_CTRL     8'h00
`define DTR_IDX_LOWCNT   8'h04
`define DTR_IDX_HIGHCNT  8'h05
`define DTR_IDX_RLD_LO   8'h06
`define DTR_IDX_RLD_HI   8'h07
`define DTR_IDX_CAP_LO   8'h08
`define DTR_IDX_IRQ_STS  8'h09
`define DTR_IDX_IRQ_MSK  8'h0A
`define DTR_IDX_CAP_HI   8'h0B
`define DTR_IDX_STATUS   8'h0C
// byte addresses on the register bus
`define DTR_OFF_CTRL     8'h00
`define DTR_OFF_LOWCNT   8'h10
`define DTR_OFF_HIGHCNT  8'h14
`define DTR_OFF_RLD_LO   8'h18
`define DTR_OFF_RLD_HI   8'h1C
`define DTR_OFF_CAP_LO   8'h20
`define DTR_OFF_IRQ_STS  8'h24
`define DTR_OFF_IRQ_MSK  8'h28
`define DTR_OFF_CAP_HI   8'h2C
`define DTR_OFF_STATUS   8'h30
`define DTR_BIT_RUN      7
`define DTR_BIT_SINGLE   6
`define DTR_BIT_TOUT     5
`define DTR_BIT_CAPMSK   2
`define DTR_BIT_TOMSK    1
`define DTR_BIT_PINSEL   0
`define DTR_CLK_LSB      3
`define DTR_IRQ_NTO      0
`define DTR_IRQ_WTO      1
`define DTR_RST_BYTE     8'h00
`define DTR_RST_WIDE     16'h0000
`define DTR_WIDE_ZERO_RL 16'hFFFE
`define DTR_RESP_OKAY    2'b00
`define DTR_RESP_SLVERR  2'b10
`endif

// ### hw/dtr_pkg.sv
// types for the dual timer register bank
package dtr_pkg;
    typedef struct packed {
        logic       run;
        logic       single;
        logic       tout;
        logic [1:0] clk_sel;
        logic       cap_msk;
        logic       to_msk;
        logic       pin_sel;
    } dtr_ctrl_t;

    typedef enum logic [1:0] {
        DTR_LVL_LOW  = 2'b00,
        DTR_LVL_HIGH = 2'b01
    } dtr_level_t;
endpackage : dtr_pkg

// ### hw/dtr_top.sv
// dual timer register bank with axi4-lite slave and counting engines
//
// Functional notes
// RULE_01 - wide capture low register is read-only; returns last captured low byte.
// RULE_02 - capture and reload registers hold through stop recovery; reset clears them.
// RULE_03 - read/write register supplies high byte of wide counter load value.
// RULE_04 - read/write register supplies low byte of wide counter load value.
// RULE_05 - high-level count sets length while narrow output is one.
// RULE_06 - low-level count sets length while narrow output is zero.
// RULE_07 - time-out flag clears only when software writes one to it.
// RULE_08 - software should clear the time-out flag before enabling timers.
// RULE_09 - read-modify-write of control may clear a set flag by accident.
// RULE_10 - control register field layout, all fields reset to zero.
// RULE_11 - clock select gives system clock divided by one, two, four, eight.
// RULE_12 - single-pass stops narrow counter at terminal count; else reload.
// RULE_13 - wide initial count of one forbidden; zero runs down from FFFEh.
// RULE_14 - time-out interrupt asserted while flag set and its mask is one.
// RULE_15 - reload values enter counters only at a load event.
//
// The AXI4-Lite slave port was left to the implementer.
`include "dtr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module dtr_top
    import dtr_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // stop-mode recovery event
    input  wire logic        stop_recover,
    // wide counter run and capture control
    input  wire logic        wide_run,
    input  wire logic        wide_capture,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // timer outputs
    output logic             narrow_out_q,
    output logic             narrow_pin_en_q,
    output logic             irq_q
);

    // ==================================================================
    // register state
    dtr_ctrl_t   ctrl_q;
    logic [7:0]  low_cnt_q;
    logic [7:0]  high_cnt_q;
    logic [7:0]  rld_lo_q;
    logic [7:0]  rld_hi_q;
    logic [15:0] cap_q;
    logic [1:0]  irq_sts_q;
    logic [1:0]  irq_msk_q;
    logic [7:0]  ncnt_q;
    logic [15:0] wcnt_q;
    logic [2:0]  div_q;
    dtr_level_t  lvl_q;
    logic        nload_q;

    // ==================================================================
    // axi write channel capture
    logic [7:0]  aw_addr_q;
    logic        aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_have_q;
    logic        wr_fire;
    logic        byte_wr;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign byte_wr = wr_fire && w_strb_q[0];

    // address and data taken in either order
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // ready while slot empty
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    function automatic logic addr_known(input logic [7:0] a);
        unique case (a)
            `DTR_OFF_CTRL, `DTR_OFF_LOWCNT, `DTR_OFF_HIGHCNT,
            `DTR_OFF_RLD_LO, `DTR_OFF_RLD_HI, `DTR_OFF_CAP_LO,
            `DTR_OFF_IRQ_STS, `DTR_OFF_IRQ_MSK, `DTR_OFF_CAP_HI,
            `DTR_OFF_STATUS: addr_known = 1'b1;
            default:         addr_known = 1'b0;
        endcase
    endfunction : addr_known

    // write response, one cycle after both halves held
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DTR_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr_q) ? `DTR_RESP_OKAY
                                                  : `DTR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==================================================================
    // divider and event terms
    logic       tick;
    logic       ntc;
    logic       wtc;
    logic [7:0] nlen;

    function automatic logic div_hit(input logic [2:0] d,
                                     input logic [1:0] sel);
        unique case (sel)
            2'b00: div_hit = 1'b1;
            2'b01: div_hit = d[0];
            2'b10: div_hit = &d[1:0];
            2'b11: div_hit = &d;
        endcase
    endfunction : div_hit

    assign tick = ctrl_q.run && div_hit(div_q, ctrl_q.clk_sel);   // RULE_11
    assign ntc  = tick && !nload_q && (ncnt_q <= 8'h01);
    assign wtc  = wide_run && (wcnt_q == 16'h0001);
    assign nlen = (lvl_q == DTR_LVL_HIGH) ? high_cnt_q : low_cnt_q;

    // free-running prescaler
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    // ==================================================================
    // control register, hardware set wins over software clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= dtr_ctrl_t'(`DTR_RST_BYTE);                 // RULE_10
        end else begin
            if (byte_wr && aw_addr_q == `DTR_OFF_CTRL) begin
                ctrl_q.run     <= w_data_q[`DTR_BIT_RUN];
                ctrl_q.single  <= w_data_q[`DTR_BIT_SINGLE];
                ctrl_q.clk_sel <= w_data_q[`DTR_CLK_LSB+:2];
                ctrl_q.cap_msk <= w_data_q[`DTR_BIT_CAPMSK];
                ctrl_q.to_msk  <= w_data_q[`DTR_BIT_TOMSK];
                ctrl_q.pin_sel <= w_data_q[`DTR_BIT_PINSEL];
                if (w_data_q[`DTR_BIT_TOUT]) begin
                    ctrl_q.tout <= 1'b0;                          // RULE_07
                end
            end
            if (ntc) begin
                ctrl_q.tout <= 1'b1;
                if (ctrl_q.single) begin
                    ctrl_q.run <= 1'b0;                           // RULE_12
                end
            end
        end
    end

    // ==================================================================
    // hold registers, untouched by stop recovery
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            low_cnt_q  <= `DTR_RST_BYTE;                          // RULE_02
            high_cnt_q <= `DTR_RST_BYTE;
            rld_lo_q   <= `DTR_RST_BYTE;
            rld_hi_q   <= `DTR_RST_BYTE;
        end else if (byte_wr) begin
            unique case (aw_addr_q)
                `DTR_OFF_LOWCNT:  low_cnt_q  <= w_data_q[7:0];     // RULE_06
                `DTR_OFF_HIGHCNT: high_cnt_q <= w_data_q[7:0];     // RULE_05
                `DTR_OFF_RLD_LO:  rld_lo_q   <= w_data_q[7:0];     // RULE_04
                `DTR_OFF_RLD_HI:  rld_hi_q   <= w_data_q[7:0];     // RULE_03
                default:          ;
            endcase
        end
    end

    // ==================================================================
    // narrow counter: load on the tick after a level change, count down
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ncnt_q       <= `DTR_RST_BYTE;
            lvl_q        <= DTR_LVL_LOW;
            nload_q      <= 1'b1;
            narrow_out_q <= 1'b0;
        end else if (!ctrl_q.run) begin
            nload_q <= 1'b1;
        end else if (tick) begin
            if (nload_q) begin
                ncnt_q  <= nlen;                                  // RULE_15
                nload_q <= 1'b0;
            end else if (ncnt_q <= 8'h01) begin
                lvl_q        <= (lvl_q == DTR_LVL_HIGH) ? DTR_LVL_LOW
                                                        : DTR_LVL_HIGH;
                narrow_out_q <= (lvl_q != DTR_LVL_HIGH);
                nload_q      <= !ctrl_q.single;
            end else begin
                ncnt_q <= ncnt_q - 8'h01;
            end
        end
    end

    // ==================================================================
    // wide counter and capture register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wcnt_q <= `DTR_RST_WIDE;
            cap_q  <= `DTR_RST_WIDE;                              // RULE_02
        end else begin
            if (wide_capture) begin
                cap_q <= wcnt_q;                                  // RULE_01
            end
            if (!wide_run || wtc) begin
                wcnt_q <= ({rld_hi_q, rld_lo_q} == `DTR_RST_WIDE) // RULE_15
                          ? `DTR_WIDE_ZERO_RL : {rld_hi_q, rld_lo_q};
            end else begin
                wcnt_q <= wcnt_q - 16'h0001;
            end
        end
    end

    // ==================================================================
    // interrupt status, mask and output
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_sts_q <= 2'b00;
            irq_msk_q <= 2'b00;
        end else begin
            if (byte_wr && aw_addr_q == `DTR_OFF_IRQ_MSK) begin
                irq_msk_q <= w_data_q[1:0];
            end
            irq_sts_q[`DTR_IRQ_NTO] <= ntc ||
                (irq_sts_q[`DTR_IRQ_NTO] &&
                 !(byte_wr && aw_addr_q == `DTR_OFF_IRQ_STS &&
                   w_data_q[`DTR_IRQ_NTO]));
            irq_sts_q[`DTR_IRQ_WTO] <= wtc ||
                (irq_sts_q[`DTR_IRQ_WTO] &&
                 !(byte_wr && aw_addr_q == `DTR_OFF_IRQ_STS &&
                   w_data_q[`DTR_IRQ_WTO]));
        end
    end

    // level interrupt and pin enable
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_q           <= 1'b0;
            narrow_pin_en_q <= 1'b0;
        end else begin
            irq_q <= (ctrl_q.tout && ctrl_q.to_msk) ||            // RULE_14
                     |(irq_sts_q & irq_msk_q);
            narrow_pin_en_q <= ctrl_q.pin_sel;
        end
    end

    // ==================================================================
    // read channel
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (s_axi_araddr)
            `DTR_OFF_CTRL:    rd_byte = ctrl_q;
            `DTR_OFF_LOWCNT:  rd_byte = low_cnt_q;
            `DTR_OFF_HIGHCNT: rd_byte = high_cnt_q;
            `DTR_OFF_RLD_LO:  rd_byte = rld_lo_q;
            `DTR_OFF_RLD_HI:  rd_byte = rld_hi_q;
            `DTR_OFF_CAP_LO:  rd_byte = cap_q[7:0];               // RULE_01
            `DTR_OFF_IRQ_STS: rd_byte = {6'h00, irq_sts_q};
            `DTR_OFF_IRQ_MSK: rd_byte = {6'h00, irq_msk_q};
            `DTR_OFF_CAP_HI:  rd_byte = cap_q[15:8];
            `DTR_OFF_STATUS:  rd_byte = {7'h00, narrow_out_q};
            default:          rd_byte = 8'h00;
        endcase
    end

    // one read at a time, answer the cycle after the address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DTR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= addr_known(s_axi_araddr) ? `DTR_RESP_OKAY
                                                      : `DTR_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==================================================================
    // assertions
    AST_TOUT_CLR: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_07
        ctrl_q.tout && !ntc && !(byte_wr && aw_addr_q == `DTR_OFF_CTRL &&
        w_data_q[`DTR_BIT_TOUT]) |=> ctrl_q.tout)
        else $error("time-out flag lost without a one written");
    AST_TOUT_SET: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_12
        ntc |=> ctrl_q.tout)
        else $error("terminal count did not set time-out flag");
    AST_SINGLE_STOP: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_12
        ntc && ctrl_q.single |=> !ctrl_q.run)
        else $error("single-pass counter kept running");
    AST_IRQ: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_14
        ctrl_q.tout && ctrl_q.to_msk |=> irq_q)
        else $error("time-out interrupt missing");
    AST_CAP_RO: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_01
        !wide_capture |=> cap_q == $past(cap_q))
        else $error("capture changed without capture event");
    AST_HOLD_STOP: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_02
        stop_recover && !byte_wr |=> rld_lo_q == $past(rld_lo_q))
        else $error("reload changed on stop recovery");
    AST_NLOAD: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_05
        tick && nload_q && lvl_q == DTR_LVL_HIGH |=> ncnt_q == $past(high_cnt_q))
        else $error("high level length not loaded");
    AST_NLOAD_LO: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_06
        tick && nload_q && lvl_q == DTR_LVL_LOW |=> ncnt_q == $past(low_cnt_q))
        else $error("low level length not loaded");
    AST_DIV8: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_11
        tick && ctrl_q.clk_sel == 2'b11 && $stable(ctrl_q) |=> !tick [*7])
        else $error("divide by eight ticked early");
    AST_WLOAD: assert property (@(posedge sys_clk) disable iff (!resetn) // RULE_15
        wtc && {rld_hi_q, rld_lo_q} > 16'h0001 |=> wcnt_q == $past({rld_hi_q, rld_lo_q}))
        else $error("wide counter not reloaded");

endmodule : dtr_top

`default_nettype wire

// ### tb/dtr_top_tb_top.sv
// self-checking bench for the dual timer register bank
`include "dtr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module dtr_top_tb_top;
    // ==========================================
    // design ports and bench counters
    logic        sys_clk;
    logic        resetn;
    logic        stop_recover;
    logic        wide_run;
    logic        wide_capture;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        narrow_out_q;
    logic        narrow_pin_en_q;
    logic        irq_q;
    int          error_cnt;
    int          tests_run;
    // mapped byte registers in table order
    localparam logic [7:0] MAP [6] = '{`DTR_OFF_CTRL, `DTR_OFF_LOWCNT,
                                       `DTR_OFF_HIGHCNT, `DTR_OFF_RLD_LO,
                                       `DTR_OFF_RLD_HI, `DTR_OFF_CAP_LO};

    dtr_top dtr_top_inst (
        .sys_clk, .resetn, .stop_recover, .wide_run, .wide_capture,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .narrow_out_q, .narrow_pin_en_q, .irq_q
    );

    // ==========================================
    // verdict, comparison and limits
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_word(input logic [31:0] exp, input logic [31:0] act);
        tests_run++;
        if (act !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask : check_word

    // a wait that runs out ends the run
    task automatic give_up();
        error_cnt++;
        $display("MISMATCH t=%0t wait limit exp=%h act=%h", $time, 1'b1, 1'b0);
        report_and_stop();
    endtask : give_up

    // ==========================================
    // register bus master
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int   n;
        logic aw_p;
        logic w_p;
        logic got;
        n = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        got = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!got) begin
            @(posedge sys_clk);
            n++;
            if (aw_p && s_axi_awready === 1'b1) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                got = 1'b1;
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
            if (n > 200) give_up();
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int   n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!got) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                got = 1'b1;
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
            if (n > 200) give_up();
        end
    endtask : axi_read

    // write and compare the response code
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `DTR_RESP_OKAY);
        logic [1:0] r;
        axi_write(a, d, r);
        check_word({30'h0, er}, {30'h0, r});
    endtask : wr

    // read and compare data and response code
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = `DTR_RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check_word(e, d);
        check_word({30'h0, er}, {30'h0, r});
    endtask : rd

    // irq output settles within a few cycles
    task automatic wait_irq(input logic v);
        for (int n = 0; n < 20 && irq_q !== v; n++) @(posedge sys_clk);
        check_word({31'h0, v}, {31'h0, irq_q});
    endtask : wait_irq

    // cycles until the narrow output shows level v
    task automatic wait_out(input logic v, output int c);
        c = 0;
        while (narrow_out_q !== v) begin
            @(posedge sys_clk);
            c++;
            if (c > 1000) give_up();
        end
    endtask : wait_out

    // ==========================================
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ==========================================
    // main sequence
    initial begin : main
        int          hi;
        int          lo;
        int          c;
        logic [31:0] d;
        logic [1:0]  r;
        error_cnt = 0;
        tests_run = 0;
        resetn = 1'b0;
        stop_recover = 1'b0;
        wide_run = 1'b0;
        wide_capture = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // reset values, then byte-wide read/write with upper bits dropped
        for (int i = 0; i < 6; i++) rd(MAP[i], 32'h0000_0000);
        for (int i = 1; i < 5; i++) begin
            wr(MAP[i], 32'hABCD_EF00 | (8'hA5 ^ (i << 4)));
            rd(MAP[i], 32'(8'hA5 ^ (i << 4)));
        end
        // unmapped place is refused
        wr(8'h3C, 32'h0000_0001, `DTR_RESP_SLVERR);
        rd(8'h3C, 32'h0000_0000, `DTR_RESP_SLVERR);
        // capture of the held wide count, writes to capture ignored
        wr(`DTR_OFF_RLD_HI, 32'h0000_0012);
        wr(`DTR_OFF_RLD_LO, 32'h0000_0034);
        repeat (4) @(posedge sys_clk);
        wide_capture <= 1'b1;
        @(posedge sys_clk);
        wide_capture <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(`DTR_OFF_CAP_LO, 32'h0000_0034);
        wr(`DTR_OFF_CAP_LO, 32'h0000_00FF);
        rd(`DTR_OFF_CAP_LO, 32'h0000_0034);
        rd(`DTR_OFF_CAP_HI, 32'h0000_0012);
        // stop-mode recovery keeps every hold value and the low capture byte
        stop_recover <= 1'b1;
        repeat (3) @(posedge sys_clk);
        stop_recover <= 1'b0;
        rd(`DTR_OFF_LOWCNT, 32'h0000_00B5);
        rd(`DTR_OFF_HIGHCNT, 32'h0000_0085);
        rd(`DTR_OFF_RLD_LO, 32'h0000_0034);
        rd(`DTR_OFF_RLD_HI, 32'h0000_0012);
        rd(`DTR_OFF_CAP_LO, 32'h0000_0034);
        // level lengths at each counting rate, high 4 and low 8
        wr(`DTR_OFF_HIGHCNT, 32'h0000_0004);
        wr(`DTR_OFF_LOWCNT, 32'h0000_0008);
        for (int s = 0; s < 4; s++) begin
            wr(`DTR_OFF_CTRL, 32'h0000_0081 | (s << 3));
            wait_out(1'b0, c);
            wait_out(1'b1, c);
            wait_out(1'b0, hi);
            wait_out(1'b1, lo);
            check_word(32'(lo - hi), 32'(4 << s));
            check_word(32'h0000_0001, {31'h0, narrow_pin_en_q});
            wr(`DTR_OFF_CTRL, 32'h0000_0000);
        end
        // flag clear by one only, cleared before enabling, then single pass
        wr(`DTR_OFF_CTRL, 32'h0000_0020);
        wr(`DTR_OFF_IRQ_STS, 32'h0000_0003);
        rd(`DTR_OFF_CTRL, 32'h0000_0000);
        wr(`DTR_OFF_CTRL, 32'h0000_00C0);
        d = 32'h0000_0000;
        for (int n = 0; n < 40 && d[5] !== 1'b1; n++) begin
            axi_read(`DTR_OFF_CTRL, d, r);
        end
        check_word(32'h0000_0060, d);
        wait_irq(1'b0);
        // flag bit written as zero, not read back and modified
        wr(`DTR_OFF_CTRL, 32'h0000_0042);
        wait_irq(1'b1);
        rd(`DTR_OFF_CTRL, 32'h0000_0062);
        wr(`DTR_OFF_CTRL, 32'h0000_0022);
        rd(`DTR_OFF_CTRL, 32'h0000_0002);
        wait_irq(1'b0);
        // sticky status with mask and clear by one
        rd(`DTR_OFF_IRQ_STS, 32'h0000_0001);
        wr(`DTR_OFF_IRQ_MSK, 32'h0000_0001);
        wait_irq(1'b1);
        wr(`DTR_OFF_IRQ_STS, 32'h0000_0001);
        wait_irq(1'b0);
        rd(`DTR_OFF_IRQ_STS, 32'h0000_0000);
        // wide terminal count reloads and sets its sticky bit
        wr(`DTR_OFF_RLD_HI, 32'h0000_0000);
        wr(`DTR_OFF_RLD_LO, 32'h0000_0003);
        wide_run <= 1'b1;
        repeat (10) @(posedge sys_clk);
        wide_run <= 1'b0;
        rd(`DTR_OFF_IRQ_STS, 32'h0000_0002);
        report_and_stop();
    end
endmodule : dtr_top_tb_top

`default_nettype wire
